// ### src/alu_pkg.sv
package alu_pkg;

   localparam int DATA_W    = 8;
   localparam int NIBBLE_W  = 4;
   localparam int ADDR_W    = 8;

   // register map
   localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
   localparam logic [31:0] OFS_WORK   = 32'h0000_0004;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
   localparam logic [31:0] OFS_MEMLO  = 32'h0000_0100;
   localparam int          MEM_DEPTH  = 64;

   // status field positions
   localparam int ST_BORROW_INV = 0;
   localparam int ST_HALF       = 1;
   localparam int ST_NULL       = 2;
   localparam int ST_WRAP       = 3;

   localparam logic [7:0] WORK_RST   = 8'h00;
   localparam logic [3:0] STATUS_RST = 4'h0;

   // ctrl register fields
   localparam int CTRL_OP_LSB   = 0;
   localparam int CTRL_ADDR_LSB = 8;
   localparam int CTRL_IMM_LSB  = 16;
   localparam int CTRL_GO       = 31;

   typedef enum logic [2:0] {
      OP_SUB_MEM   = 3'h1,
      OP_SUB_INTO  = 3'h2,
      OP_SUB_IMM   = 3'h3,
      OP_SWAP      = 3'h4
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } state_t;

endpackage

// ### src/sub_core.sv
`timescale 1ns/100ps
`default_nettype none
module sub_core
   import alu_pkg::*;
(
   input  wire logic [7:0] minuend_i,
   input  wire logic [7:0] subtrahend_i,
   output logic      [7:0] diff_o,
   output logic            borrow_inv_o,
   output logic            half_o,
   output logic            null_o,
   output logic            wrap_o
);
   logic [8:0] full;
   logic [4:0] low;

   always_comb begin
      full         = {1'b0, minuend_i} - {1'b0, subtrahend_i};
      low          = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]};
      diff_o       = full[7:0];
      borrow_inv_o = ~full[8];
      half_o       = ~low[4];
      null_o       = (full[7:0] == 8'h00);
      wrap_o       = (minuend_i[7] ^ subtrahend_i[7]) & (minuend_i[7] ^ full[7]);
   end
endmodule
`default_nettype wire

// ### src/nibble_swap.sv
`timescale 1ns/100ps
`default_nettype none
module nibble_swap
   import alu_pkg::*;
(
   input  wire logic [7:0] byte_i,
   output logic      [7:0] byte_o
);
   assign byte_o = {byte_i[3:0], byte_i[7:4]};
endmodule
`default_nettype wire

// ### src/subtract_and_nibble_swap_alu.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - sub from memory: working register minus memory byte goes to working register.
// - minus_into_memory: working register minus memory byte goes to memory.
// - immediate sub: working register minus literal goes to working register.
// - borrow_inverse_flag is 0 on negative result, 1 on zero or positive.
// - subtracts update all four status flags; nibble_exchange leaves them alone.
// - nibble_exchange swaps high and low nibbles of the memory byte.
module subtract_and_nibble_swap_alu
   import alu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             busy_o
);
   ////////////////////////////////////////////////////////////////
   // registered state
   logic [7:0]  mem [MEM_DEPTH];
   logic [7:0]  working_register;
   logic [7:0]  next_working_register;
   logic [3:0]  status;
   logic [3:0]  next_status;
   logic [2:0]  op;
   logic [2:0]  next_op;
   logic [7:0]  addr;
   logic [7:0]  next_addr;
   logic [7:0]  imm;
   logic [7:0]  next_imm;
   state_t      state;
   state_t      next_state;
   logic        ack;
   logic        next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;

   // memory write port
   logic        mem_we;
   logic [5:0]  mem_idx;
   logic [7:0]  mem_wdata;

   // datapath taps
   logic [7:0]  operand;
   logic [7:0]  mem_byte;
   logic [7:0]  diff;
   logic [7:0]  swapped;
   logic        f_borrow_inv;
   logic        f_half;
   logic        f_null;
   logic        f_wrap;
   logic [3:0]  flag_new;

   // bus decode
   logic        req;
   logic        wr_req;
   logic        rd_req;
   logic        bus_mem;
   logic        bus_idx_ok;
   logic [5:0]  bus_idx;
   logic        hit_ctrl;
   logic        hit_work;
   logic        hit_status;
   logic        hit_mem;
   logic        wr_ctrl;
   logic        wr_work;
   logic        wr_status;
   logic        wr_mem;
   logic [31:0] rd_word;

   // execute decode
   logic        exec_go;
   logic        is_sub;
   logic        exec_work;
   logic        exec_mem;
   logic        exec_swap;

   ////////////////////////////////////////////////////////////////
   // bus decode; requests are taken only while idle
   assign req        = cyc_i & stb_i & ~ack & (state == ST_IDLE);
   assign wr_req     = req & we_i;
   assign rd_req     = req & ~we_i;

   assign bus_idx    = adr_i[7:2];
   assign bus_mem    = (adr_i[31:8] == OFS_MEMLO[31:8]);
   // misaligned memory addresses count as unmapped
   assign bus_idx_ok = (adr_i[1:0] == 2'b00);

   assign hit_ctrl   = (adr_i == OFS_CTRL);
   assign hit_work   = (adr_i == OFS_WORK);
   assign hit_status = (adr_i == OFS_STATUS);
   assign hit_mem    = bus_mem & bus_idx_ok;

   // ctrl needs its top lane, so a write without sel_i[3] cannot start an operation
   assign wr_ctrl    = wr_req & hit_ctrl & sel_i[3];
   assign wr_work    = wr_req & hit_work & sel_i[0];
   assign wr_status  = wr_req & hit_status & sel_i[0];
   assign wr_mem     = wr_req & hit_mem & sel_i[0];

   ////////////////////////////////////////////////////////////////
   // execute decode
   assign exec_go    = (state == ST_EXEC);
   assign is_sub     = (op == OP_SUB_MEM) | (op == OP_SUB_INTO) | (op == OP_SUB_IMM);
   assign exec_work  = exec_go & ((op == OP_SUB_MEM) | (op == OP_SUB_IMM));
   assign exec_mem   = exec_go & (op == OP_SUB_INTO);
   assign exec_swap  = exec_go & (op == OP_SWAP);

   ////////////////////////////////////////////////////////////////
   // operand select
   assign mem_byte   = mem[addr[5:0]];
   assign operand    = (op == OP_SUB_IMM) ? imm : mem_byte;

   sub_core u_sub (
      .minuend_i    (working_register),
      .subtrahend_i (operand),
      .diff_o       (diff),
      .borrow_inv_o (f_borrow_inv),
      .half_o       (f_half),
      .null_o       (f_null),
      .wrap_o       (f_wrap)
   );

   nibble_swap u_swap (
      .byte_i (mem_byte),
      .byte_o (swapped)
   );

   ////////////////////////////////////////////////////////////////
   // subtract flags in status bit order
   always_comb begin
      flag_new                = status;
      flag_new[ST_BORROW_INV] = f_borrow_inv;
      flag_new[ST_HALF]       = f_half;
      flag_new[ST_NULL]       = f_null;
      flag_new[ST_WRAP]       = f_wrap;
   end

   ////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_word = {24'h00_0000, 5'h00, op};
      end else if (hit_work) begin
         rd_word = {24'h00_0000, working_register};
      end else if (hit_status) begin
         rd_word = {28'h000_0000, status};
      end else if (hit_mem) begin
         rd_word = {24'h00_0000, mem[bus_idx]};
      end else begin
         // unmapped reads answer zero
         rd_word = 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////
   // bus answer
   always_comb begin
      next_ack   = 1'b0;
      next_rdata = rdata;
      if (req) begin
         next_ack   = 1'b1;
         next_rdata = 32'h0000_0000;
         if (rd_req) begin
            next_rdata = rd_word;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack   <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // command and sequencing
   always_comb begin
      next_op    = op;
      next_addr  = addr;
      next_imm   = imm;
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (wr_ctrl) begin
               next_op   = dat_i[CTRL_OP_LSB +: 3];
               next_addr = dat_i[CTRL_ADDR_LSB +: 8];
               next_imm  = dat_i[CTRL_IMM_LSB +: 8];
               if (dat_i[CTRL_GO]) begin
                  next_state = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            // bus held off one cycle, keeps memory single-ported
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op    <= 3'h0;
         addr  <= 8'h00;
         imm   <= 8'h00;
         state <= ST_IDLE;
      end else begin
         op    <= next_op;
         addr  <= next_addr;
         imm   <= next_imm;
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////
   // working register
   always_comb begin
      next_working_register = working_register;
      if (wr_work) begin
         next_working_register = dat_i[7:0];
      end
      if (exec_work) begin
         next_working_register = diff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         working_register <= WORK_RST;
      end else begin
         working_register <= next_working_register;
      end
   end

   ////////////////////////////////////////////////////////////////
   // status flags
   always_comb begin
      next_status = status;
      if (wr_status) begin
         next_status = dat_i[3:0];
      end
      // only subtracts move the four flags; swap leaves them alone
      if (exec_go && is_sub) begin
         next_status = flag_new;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   ////////////////////////////////////////////////////////////////
   // memory write port; bus and execute never share a cycle
   always_comb begin
      mem_we    = 1'b0;
      mem_idx   = addr[5:0];
      mem_wdata = 8'h00;
      if (wr_mem) begin
         mem_we    = 1'b1;
         mem_idx   = bus_idx;
         mem_wdata = dat_i[7:0];
      end else if (exec_mem) begin
         mem_we    = 1'b1;
         mem_idx   = addr[5:0];
         mem_wdata = diff;
      end else if (exec_swap) begin
         mem_we    = 1'b1;
         mem_idx   = addr[5:0];
         mem_wdata = swapped;
      end
   end

   // memory has no reset; contents are software's to load
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         mem[mem_idx] <= mem_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign ack_o  = ack;
   assign dat_o  = rdata;
   assign busy_o = exec_go;
endmodule
`default_nettype wire

// ### sim/alu_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module alu_chk
   import alu_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        busy_o
);
   logic take;
   assign take = cyc_i && stb_i && !ack_o && !busy_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_go; take && we_i && adr_i == OFS_CTRL && sel_i[3] && dat_i[CTRL_GO]
      |=> ack_o && busy_o ##1 !busy_o; endproperty
   a_go: assert property (p_go) else $error("no execute after go");
   property p_ack; take |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_busy_src; busy_o |-> ack_o && $past(we_i && adr_i == OFS_CTRL
      && dat_i[CTRL_GO]); endproperty
   a_busy_src: assert property (p_busy_src) else $error("busy without go");
   property p_busy_one; busy_o |=> !busy_o && !ack_o; endproperty
   a_busy_one: assert property (p_busy_one) else $error("busy too long");
   property p_unmap; take && !we_i && adr_i == 32'h0000_0040 |=> ack_o && dat_o == 0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_pulse; ack_o |=> !ack_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   property p_idle; !cyc_i ##1 !cyc_i |-> !ack_o; endproperty
   a_idle: assert property (p_idle) else $error("ack without request");
endmodule
bind subtract_and_nibble_swap_alu alu_chk alu_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o));
`default_nettype wire

// ### sim/subtract_and_nibble_swap_alu_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module subtract_and_nibble_swap_alu_tb_top;
   import alu_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, busy_o;
   logic [31:0] adr_i = 0, dat_i = 0, dat_o, q, ma;
   logic [3:0]  sel_i = 0;
   logic [7:0]  w, m, d;
   logic [7:0]  wv [5] = '{8'h50, 8'h30, 8'h80, 8'h42, 8'h10};
   logic [7:0]  mv [5] = '{8'h30, 8'h50, 8'h01, 8'h42, 8'h01};
   int          num_errors = 0, checked = 0, op;
   always #5 clk_i = ~clk_i;
   subtract_and_nibble_swap_alu subtract_and_nibble_swap_alu_inst (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o));
   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("errors %0d checked %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // ack and data sampled at the same edge, release only after it
   task wb(input logic [31:0] a, input logic wr, input logic [31:0] dv);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1; stb_i <= 1; we_i <= wr; adr_i <= a; dat_i <= dv; sel_i <= 4'hf;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
      if (ack_o !== 1'b1) begin num_errors++; end_of_test; end
   endtask
   function logic [3:0] flags(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] df;
      df = a - b;
      return {(a[7] != b[7]) && (df[7] != a[7]), df == 8'h00, a[3:0] >= b[3:0], a >= b};
   endfunction
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      wb(OFS_WORK, 0, 0); chk(q[7:0], WORK_RST);
      wb(OFS_STATUS, 0, 0); chk(q[3:0], STATUS_RST);
      // flags preset inverted so a flag that never updates shows up
      for (int k = 0; k < 15; k++) begin
         w = wv[k % 5]; m = mv[k % 5]; op = k / 5 + 1; d = w - m; ma = OFS_MEMLO + 4 * k;
         wb(ma, 1, {24'h0, m}); wb(OFS_WORK, 1, {24'h0, w});
         wb(OFS_STATUS, 1, {28'h0, ~flags(w, m)});
         wb(OFS_CTRL, 1, {8'h80, m, 8'(k), 8'(op)});
         wb(OFS_WORK, 0, 0); chk(q[7:0], op == 2 ? w : d);
         wb(ma, 0, 0); chk(q[7:0], op == 2 ? d : m);
         wb(OFS_STATUS, 0, 0); chk(q[3:0], flags(w, m));
      end
      wb(OFS_MEMLO + 252, 1, 32'h0000_003c); wb(OFS_STATUS, 1, 32'h0000_0005);
      wb(OFS_CTRL, 1, 32'h8000_3f04);
      wb(OFS_MEMLO + 252, 0, 0); chk(q[7:0], 8'hc3);
      wb(OFS_MEMLO + 253, 1, 32'h0000_00aa); wb(OFS_MEMLO + 252, 0, 0); chk(q[7:0], 8'hc3);
      wb(OFS_STATUS, 0, 0); chk(q[3:0], 4'h5);
      wb(32'h0000_0040, 0, 0); chk(q, 0);
      end_of_test;
   end
endmodule
`default_nettype wire
